// ### verilog/bx_byte_op_execute.sv
// Execute unit for a subset of byte operations, with AXI4-Lite registers.
// Assumes one clock, ref_clk, and a master that keeps AXI4-Lite handshakes.
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module bx_byte_op_execute (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        bx_pkg::bx_fsm_t fsm;
        bx_pkg::bx_op_t op;
        logic dest;
        logic [6:0] fAddr;
        logic [10:0] lit;
        logic [7:0] wReg;
        logic carry;
        logic zero;
        logic [6:0] latch;
        logic [14:0] pc;
        logic [6:0] fileSel;
        logic skipPend;
        logic [15:0] cycles;
        logic [127:0][7:0] file;
        logic awReady;
        logic awHeld;
        logic [7:0] awAddr;
        logic wReady;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } bx_regs_t;

    localparam bx_regs_t BX_RESET = '{
        fsm: bx_pkg::ST_IDLE,
        op: bx_pkg::OP_NOP,
        wReg: bx_pkg::RST_W,
        latch: bx_pkg::RST_LATCH,
        pc: bx_pkg::RST_PC,
        awReady: 1'b1,
        wReady: 1'b1,
        arReady: 1'b1,
        default: '0
    };

    bx_regs_t core_reg;
    bx_regs_t core_next;
    logic [7:0] srcByte;
    logic [7:0] resultByte;
    logic [31:0] wrData;
    logic doWrite;
    logic idle;
    logic destWr;

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic isMapped(input logic [7:0] a);
        logic hit;
        hit = 1'b1;
        if (a == bx_pkg::OFS_CMD) begin
            hit = 1'b1;
        end else if (a == bx_pkg::OFS_W) begin
            hit = 1'b1;
        end else if (a == bx_pkg::OFS_STATUS) begin
            hit = 1'b1;
        end else if (a == bx_pkg::OFS_LATCH) begin
            hit = 1'b1;
        end else if (a == bx_pkg::OFS_PC) begin
            hit = 1'b1;
        end else if (a == bx_pkg::OFS_FSEL) begin
            hit = 1'b1;
        end else if (a == bx_pkg::OFS_FDATA) begin
            hit = 1'b1;
        end else if (a == bx_pkg::OFS_CYCLES) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
        return hit;
    endfunction

    function automatic logic [31:0] regRead(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == bx_pkg::OFS_CMD) begin
            v[bx_pkg::CMD_OP_LSB +: 3] = core_reg.op;
            v[bx_pkg::CMD_DEST_BIT] = core_reg.dest;
            v[bx_pkg::CMD_FADDR_LSB +: 7] = core_reg.fAddr;
            v[bx_pkg::CMD_LIT_LSB +: 11] = core_reg.lit;
        end else if (a == bx_pkg::OFS_W) begin
            v[7:0] = core_reg.wReg;
        end else if (a == bx_pkg::OFS_STATUS) begin
            v[bx_pkg::STAT_C_BIT] = core_reg.carry;
            v[bx_pkg::STAT_Z_BIT] = core_reg.zero;
            v[bx_pkg::STAT_BUSY_BIT] = core_reg.fsm != bx_pkg::ST_IDLE;
            v[bx_pkg::STAT_SKIP_BIT] = core_reg.skipPend;
        end else if (a == bx_pkg::OFS_LATCH) begin
            v[6:0] = core_reg.latch;
        end else if (a == bx_pkg::OFS_PC) begin
            v[14:0] = core_reg.pc;
        end else if (a == bx_pkg::OFS_FSEL) begin
            v[6:0] = core_reg.fileSel;
        end else if (a == bx_pkg::OFS_FDATA) begin
            v[7:0] = core_reg.file[core_reg.fileSel];
        end else if (a == bx_pkg::OFS_CYCLES) begin
            v[15:0] = core_reg.cycles;
        end
        return v;
    endfunction

    function automatic logic [31:0] mergeLanes(input logic [31:0] old,
            input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        core_next = core_reg;
        srcByte = core_reg.file[core_reg.fAddr];
        resultByte = 8'h00;
        destWr = 1'b0;
        idle = core_reg.fsm == bx_pkg::ST_IDLE;
        doWrite = core_reg.awHeld && core_reg.wHeld && !core_reg.bValid;
        wrData = mergeLanes(regRead(core_reg.awAddr), core_reg.wData,
            core_reg.wStrb);

        // Write channels, taken in either order
        if (s_axi_awvalid && core_reg.awReady) begin
            core_next.awHeld = 1'b1;
            core_next.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && core_reg.wReady) begin
            core_next.wHeld = 1'b1;
            core_next.wData = s_axi_wdata;
            core_next.wStrb = s_axi_wstrb;
        end
        if (core_reg.bValid && s_axi_bready) begin
            core_next.bValid = 1'b0;
        end
        if (doWrite) begin
            core_next.awHeld = 1'b0;
            core_next.wHeld = 1'b0;
            core_next.bValid = 1'b1;
            core_next.bResp = isMapped(core_reg.awAddr) ?
                bx_pkg::RESP_OKAY : bx_pkg::RESP_SLVERR;
            // Writes while busy are dropped
            if (idle) begin
                if (core_reg.awAddr == bx_pkg::OFS_CMD) begin
                    core_next.op = bx_pkg::bx_op_t'(
                        wrData[bx_pkg::CMD_OP_LSB +: 3]);
                    core_next.dest = wrData[bx_pkg::CMD_DEST_BIT];
                    core_next.fAddr = wrData[bx_pkg::CMD_FADDR_LSB +: 7];
                    core_next.lit = wrData[bx_pkg::CMD_LIT_LSB +: 11];
                    core_next.fsm = bx_pkg::ST_EXEC;
                end else if (core_reg.awAddr == bx_pkg::OFS_W) begin
                    core_next.wReg = wrData[7:0];
                end else if (core_reg.awAddr == bx_pkg::OFS_STATUS) begin
                    core_next.carry = wrData[bx_pkg::STAT_C_BIT];
                    core_next.zero = wrData[bx_pkg::STAT_Z_BIT];
                end else if (core_reg.awAddr == bx_pkg::OFS_LATCH) begin
                    core_next.latch = wrData[6:0];
                end else if (core_reg.awAddr == bx_pkg::OFS_FSEL) begin
                    core_next.fileSel = wrData[6:0];
                end else if (core_reg.awAddr == bx_pkg::OFS_FDATA) begin
                    core_next.file[core_reg.fileSel] = wrData[7:0];
                end
            end
        end
        core_next.awReady = !core_next.awHeld && !core_next.bValid;
        core_next.wReady = !core_next.wHeld && !core_next.bValid;

        // Read channel
        if (core_reg.rValid && s_axi_rready) begin
            core_next.rValid = 1'b0;
        end
        if (s_axi_arvalid && core_reg.arReady) begin
            core_next.rValid = 1'b1;
            if (isMapped(s_axi_araddr)) begin
                core_next.rData = regRead(s_axi_araddr);
                core_next.rResp = bx_pkg::RESP_OKAY;
            end else begin
                core_next.rData = 32'h0000_0000;
                core_next.rResp = bx_pkg::RESP_SLVERR;
            end
        end
        core_next.arReady = !core_next.rValid;

        // Instruction execution
        case (core_reg.fsm)
            bx_pkg::ST_EXEC: begin
                core_next.cycles = core_reg.cycles + 16'h0001;
                core_next.pc = core_reg.pc + 15'h0001;
                core_next.fsm = bx_pkg::ST_IDLE;
                if (core_reg.skipPend) begin
                    core_next.skipPend = 1'b0;
                end else begin
                    case (core_reg.op)
                        bx_pkg::OP_INCREMENT: begin
                            resultByte = srcByte + 8'h01;
                            destWr = 1'b1;
                            core_next.zero = resultByte == 8'h00;
                        end
                        bx_pkg::OP_INCREMENT_SKIP_ZERO: begin
                            resultByte = srcByte + 8'h01;
                            destWr = 1'b1;
                            core_next.skipPend = resultByte == 8'h00;
                        end
                        bx_pkg::OP_JUMP_ABSOLUTE: begin
                            core_next.pc = {core_reg.latch[6:bx_pkg::LATCH_HI_LSB],
                                core_reg.lit};
                            core_next.fsm = bx_pkg::ST_SECOND;
                        end
                        bx_pkg::OP_OR_LITERAL: begin
                            resultByte = core_reg.wReg | core_reg.lit[7:0];
                            core_next.wReg = resultByte;
                            core_next.zero = resultByte == 8'h00;
                        end
                        bx_pkg::OP_OR_REGISTER: begin
                            resultByte = core_reg.wReg | srcByte;
                            destWr = 1'b1;
                            core_next.zero = resultByte == 8'h00;
                        end
                        bx_pkg::OP_SHIFT_LEFT_LOGICAL: begin
                            core_next.carry = srcByte[7];
                            resultByte = {srcByte[6:0], 1'b0};
                            destWr = 1'b1;
                            core_next.zero = resultByte == 8'h00;
                        end
                        default: begin
                        end
                    endcase
                end
                if (destWr) begin
                    if (core_reg.dest == bx_pkg::DEST_W) begin
                        core_next.wReg = resultByte;
                    end else begin
                        core_next.file[core_reg.fAddr] = resultByte;
                    end
                end
            end
            bx_pkg::ST_SECOND: begin
                core_next.cycles = core_reg.cycles + 16'h0001;
                core_next.fsm = bx_pkg::ST_IDLE;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            core_reg <= BX_RESET;
        end else if (clkEn) begin
            core_reg <= core_next;
        end
    end

    assign s_axi_awready = core_reg.awReady;
    assign s_axi_wready = core_reg.wReady;
    assign s_axi_bvalid = core_reg.bValid;
    assign s_axi_bresp = core_reg.bResp;
    assign s_axi_arready = core_reg.arReady;
    assign s_axi_rvalid = core_reg.rValid;
    assign s_axi_rdata = core_reg.rData;
    assign s_axi_rresp = core_reg.rResp;

    // ****************************************
    // Assertions
    // ****************************************
    logic execNow;
    logic [10:0] litVal;
    logic [3:0] latchHigh;
    logic [7:0] litLow;
    logic srcTop;
    logic [6:0] srcLow;
    logic [6:0] addrNow;
    bx_pkg::bx_op_t opNow;
    assign execNow = clkEn && core_reg.fsm == bx_pkg::ST_EXEC &&
        !core_reg.skipPend;
    assign opNow = core_reg.op;
    assign litVal = core_reg.lit;
    assign latchHigh = core_reg.latch[6:bx_pkg::LATCH_HI_LSB];
    assign litLow = core_reg.lit[7:0];
    assign srcTop = srcByte[7];
    assign srcLow = srcByte[6:0];
    assign addrNow = core_reg.fAddr;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    sequence seqJumpIssue;
        execNow && opNow == bx_pkg::OP_JUMP_ABSOLUTE;
    endsequence
    sequence seqJumpSecond;
        core_reg.fsm == bx_pkg::ST_SECOND;
    endsequence
    sequence seqSkipZero;
        execNow && opNow == bx_pkg::OP_INCREMENT_SKIP_ZERO &&
            resultByte == 8'h00;
    endsequence

    chk_jump_two_cycles: assert property (seqJumpIssue |=> seqJumpSecond)
        else $error("jump did not enter its second cycle");
    chk_jump_second_end: assert property (
        seqJumpSecond ##0 clkEn |=> core_reg.fsm == bx_pkg::ST_IDLE)
        else $error("jump second cycle did not end");
    chk_jump_low_bits: assert property (
        seqJumpIssue |=> core_reg.pc[10:0] == $past(litVal))
        else $error("jump low counter bits wrong");
    chk_jump_high_bits: assert property (
        seqJumpIssue |=> core_reg.pc[14:11] == $past(latchHigh))
        else $error("jump high counter bits wrong");
    chk_jump_flags_kept: assert property (seqJumpIssue |=>
        $stable(core_reg.carry) && $stable(core_reg.zero))
        else $error("jump changed a flag");
    chk_inc_zero_flag: assert property (
        execNow && opNow == bx_pkg::OP_INCREMENT |=>
        core_reg.zero == ($past(resultByte) == 8'h00))
        else $error("increment zero flag wrong");
    chk_inc_wrap_zero: assert property (
        execNow && opNow == bx_pkg::OP_INCREMENT && srcByte == 8'hFF |=>
        core_reg.zero)
        else $error("increment of all ones did not wrap");
    chk_skip_flags_kept: assert property (
        execNow && opNow == bx_pkg::OP_INCREMENT_SKIP_ZERO |=>
        $stable(core_reg.carry) && $stable(core_reg.zero))
        else $error("skip increment changed a flag");
    chk_skip_nop_next: assert property (seqSkipZero |=> core_reg.skipPend ##0
        (core_reg.fsm == bx_pkg::ST_IDLE))
        else $error("zero result did not arm the skip");
    chk_skip_consumed: assert property (
        clkEn && core_reg.skipPend && core_reg.fsm == bx_pkg::ST_EXEC |=>
        !core_reg.skipPend && $stable(core_reg.wReg) &&
        $stable(core_reg.zero))
        else $error("skipped instruction had an effect");
    chk_or_literal: assert property (
        execNow && opNow == bx_pkg::OP_OR_LITERAL |=>
        core_reg.wReg == ($past(core_reg.wReg) | $past(litLow)))
        else $error("literal OR result wrong");
    chk_or_register: assert property (
        execNow && opNow == bx_pkg::OP_OR_REGISTER && !core_reg.dest |=>
        core_reg.wReg == ($past(core_reg.wReg) | $past(srcByte)))
        else $error("register OR result wrong");
    chk_dest_w_file: assert property (
        execNow && opNow == bx_pkg::OP_INCREMENT && !core_reg.dest |=>
        core_reg.file[$past(addrNow)] == $past(srcByte))
        else $error("file register written for W destination");
    chk_shift_carry: assert property (
        execNow && opNow == bx_pkg::OP_SHIFT_LEFT_LOGICAL |=>
        core_reg.carry == $past(srcTop))
        else $error("shift carry wrong");
    chk_shift_result: assert property (
        execNow && opNow == bx_pkg::OP_SHIFT_LEFT_LOGICAL &&
        !core_reg.dest |=> core_reg.wReg == {$past(srcLow), 1'b0} &&
        core_reg.zero == ($past(srcLow) == 7'h00))
        else $error("shift result or zero flag wrong");

endmodule

`default_nettype wire

// ### verilog/bx_pkg.sv
// Constants and types for the byte operation execute block.
// Assumes an AXI4-Lite master with 32-bit data and 8-bit byte addresses.
`default_nettype none

package bx_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_W = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_LATCH = 8'h0C;
    localparam logic [7:0] OFS_PC = 8'h10;
    localparam logic [7:0] OFS_FSEL = 8'h14;
    localparam logic [7:0] OFS_FDATA = 8'h18;
    localparam logic [7:0] OFS_CYCLES = 8'h1C;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_DEST_BIT = 3;
    localparam int CMD_FADDR_LSB = 4;
    localparam int CMD_LIT_LSB = 16;
    localparam int STAT_C_BIT = 0;
    localparam int STAT_Z_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_SKIP_BIT = 3;
    localparam int LATCH_HI_LSB = 3;

    // ****************************************
    // Reset values and encodings
    // ****************************************
    localparam logic [7:0] RST_W = 8'h00;
    localparam logic [6:0] RST_LATCH = 7'h00;
    localparam logic [14:0] RST_PC = 15'h0000;
    localparam logic DEST_W = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_INCREMENT = 3'h1,
        OP_INCREMENT_SKIP_ZERO = 3'h2,
        OP_JUMP_ABSOLUTE = 3'h3,
        OP_OR_LITERAL = 3'h4,
        OP_OR_REGISTER = 3'h5,
        OP_SHIFT_LEFT_LOGICAL = 3'h6
    } bx_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_EXEC = 3'h2,
        ST_SECOND = 3'h4
    } bx_fsm_t;

endpackage

`default_nettype wire

// ### tb/bx_host_model.sv
// Host model: an AXI4-Lite master for the execute block's registers.
// Assumes each task is entered just after a rising edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none

module bx_host_model (
    input wire logic ref_clk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // ****************************************
    // Bus tasks
    // ****************************************
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
    end

    // Released address and data show the inverse, never the stale value; wstrb keeps 4'hf
    task automatic write_word(input logic [7:0] addr, input logic [31:0] data);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        s_axi_awaddr <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= data;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge ref_clk);
            if (!awDone && s_axi_awready) begin
                awDone = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~addr;
            end
            if (!wDone && s_axi_wready) begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~data;
            end
        end
        @(posedge ref_clk);
        while (!s_axi_bvalid) @(posedge ref_clk);
        s_axi_bready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic read_word(input logic [7:0] addr);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge ref_clk);
        while (!s_axi_arready) @(posedge ref_clk);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~addr;
        @(posedge ref_clk);
        while (!s_axi_rvalid) @(posedge ref_clk);
        s_axi_rready <= 1'b0;
        @(posedge ref_clk);
    endtask
endmodule

`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the byte operation execute block.
// Assumes the host model makes every register access.
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int LIMIT = 8000;
    logic ref_clk, rstn, clkEn;
    logic [7:0] s_axi_awaddr, s_axi_araddr, eW, eF, f;
    logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, eC, eZ;
    logic [14:0] ePc;
    logic [15:0] eCyc;
    logic [6:0] curSel;
    logic [33:0] rQ[$];
    logic [1:0] bQ[$];
    logic [33:0] rExp;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycleCount = 0;

    bx_byte_op_execute bx_byte_op_execute_inst (.ref_clk, .rstn, .clkEn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    bx_host_model bx_host_model_inst (.ref_clk, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
        .s_axi_rready);

    // ****************************************
    // Checking and reporting
    // ****************************************
    task automatic compare_word(input string what, input logic [31:0] e,
                                input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic compare_resp(input string what, input logic [1:0] e,
                                input logic [1:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        if (rstn && s_axi_rvalid && s_axi_rready) begin
            rExp = (rQ.size() != 0) ? rQ.pop_front() : {2'h3, 32'hdead_beef};
            compare_word("rdata", rExp[31:0], s_axi_rdata);
            compare_resp("rresp", rExp[33:32], s_axi_rresp);
        end
        if (rstn && s_axi_bvalid && s_axi_bready) begin
            compare_resp("bresp", (bQ.size() != 0) ? bQ.pop_front() : 2'h3,
                         s_axi_bresp);
        end
    end

    always @(posedge ref_clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == LIMIT) begin
            n_mismatch++;
            complete_run();
        end
    end

    // ****************************************
    // Stimulus
    // ****************************************
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] resp);
        bQ.push_back(resp);
        bx_host_model_inst.write_word(a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] resp);
        rQ.push_back({resp, d});
        bx_host_model_inst.read_word(a);
    endtask

    task automatic setup(input logic [6:0] sel, input logic [7:0] fv,
                         input logic [7:0] w, input logic c, input logic z);
        wr(bx_pkg::OFS_FSEL, {25'h0, sel}, bx_pkg::RESP_OKAY);
        wr(bx_pkg::OFS_FDATA, {24'h0, fv}, bx_pkg::RESP_OKAY);
        wr(bx_pkg::OFS_W, {24'h0, w}, bx_pkg::RESP_OKAY);
        wr(bx_pkg::OFS_STATUS, {30'h0, z, c}, bx_pkg::RESP_OKAY);
        {curSel, eF, eW, eC, eZ} = {sel, fv, w, c, z};
    endtask

    task automatic exec(input bx_pkg::bx_op_t op, input logic dest,
                        input logic [10:0] lit);
        wr(bx_pkg::OFS_CMD, {5'h0, lit, 5'h0, curSel, dest, op},
           bx_pkg::RESP_OKAY);
        ePc = ePc + 15'h1;
        eCyc = eCyc + 16'h1;
    endtask

    task automatic put(input logic dest, input logic [7:0] v);
        if (dest) eF = v;
        else eW = v;
        eZ = (v == 8'h00);
    endtask

    task automatic check_all(input logic skip);
        rd(bx_pkg::OFS_W, {24'h0, eW}, bx_pkg::RESP_OKAY);
        rd(bx_pkg::OFS_STATUS, {28'h0, skip, 1'b0, eZ, eC}, bx_pkg::RESP_OKAY);
        rd(bx_pkg::OFS_FDATA, {24'h0, eF}, bx_pkg::RESP_OKAY);
        rd(bx_pkg::OFS_PC, {17'h0, ePc}, bx_pkg::RESP_OKAY);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        {rstn, clkEn, rnd, ePc, eCyc} = {1'b0, 1'b1, 32'h0000_08ee, 31'h0};
        {curSel, eW, eF, eC, eZ} = {7'h00, bx_pkg::RST_W, 8'h00, 2'h0};
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        check_all(1'b0);
        rd(bx_pkg::OFS_LATCH, {25'h0, bx_pkg::RST_LATCH}, bx_pkg::RESP_OKAY);
        $display("test reset done");
        rnd = lfsr_step(rnd);
        setup(7'h11, rnd[7:0], rnd[15:8], 1'b1, 1'b0);
        exec(bx_pkg::OP_INCREMENT, 1'b0, 11'h000);
        put(1'b0, eF + 8'h01);
        check_all(1'b0);
        setup(7'h7f, 8'hff, rnd[23:16], 1'b0, 1'b0);
        exec(bx_pkg::OP_INCREMENT, 1'b1, 11'h000);
        put(1'b1, 8'h00);
        check_all(1'b0);
        $display("test increment done");
        setup(7'h00, 8'hfe, rnd[15:8], 1'b1, 1'b0);
        exec(bx_pkg::OP_INCREMENT_SKIP_ZERO, 1'b1, 11'h000);
        eF = 8'hff;
        check_all(1'b0);
        exec(bx_pkg::OP_INCREMENT_SKIP_ZERO, 1'b0, 11'h000);
        eW = 8'h00;
        check_all(1'b1);
        exec(bx_pkg::OP_OR_LITERAL, 1'b0, 11'h0ff);
        check_all(1'b0);
        $display("test skip done");
        wr(bx_pkg::OFS_LATCH, 32'h0000_005a, bx_pkg::RESP_OKAY);
        exec(bx_pkg::OP_JUMP_ABSOLUTE, 1'b0, 11'h7ff);
        ePc = {4'hb, 11'h7ff};
        eCyc = eCyc + 16'h1;
        check_all(1'b0);
        rd(bx_pkg::OFS_CYCLES, {16'h0, eCyc}, bx_pkg::RESP_OKAY);
        wr(bx_pkg::OFS_PC, 32'h0000_1234, bx_pkg::RESP_OKAY);
        rd(bx_pkg::OFS_PC, {17'h0, ePc}, bx_pkg::RESP_OKAY);
        $display("test jump done");
        for (int i = 0; i < 2; i++) begin
            rnd = lfsr_step(rnd);
            setup(7'h05, rnd[7:0], i ? 8'h00 : rnd[15:8], 1'b1, i == 0);
            exec(bx_pkg::OP_OR_LITERAL, 1'b0, {3'h7, i ? 8'h00 : rnd[23:16]});
            put(1'b0, eW | (i ? 8'h00 : rnd[23:16]));
            check_all(1'b0);
        end
        for (int d = 0; d < 2; d++) begin
            rnd = lfsr_step(rnd);
            setup(7'h40, rnd[7:0], rnd[15:8], 1'b0, 1'b1);
            exec(bx_pkg::OP_OR_REGISTER, d[0], 11'h000);
            put(d[0], eW | eF);
            check_all(1'b0);
        end
        $display("test or done");
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr_step(rnd);
            f = (k == 1) ? 8'h80 : {k == 0, rnd[6:0]};
            setup(7'h2a, f, rnd[15:8], ~f[7], f[6:0] != 7'h00);
            exec(bx_pkg::OP_SHIFT_LEFT_LOGICAL, k[0], 11'h000);
            eC = f[7];
            put(k[0], {f[6:0], 1'b0});
            check_all(1'b0);
        end
        $display("test shift done");
        clkEn <= 1'b0;
        repeat (4) @(posedge ref_clk);
        clkEn <= 1'b1;
        check_all(1'b0);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        {curSel, eW, eF, eC, eZ, ePc} = '0;
        check_all(1'b0);
        $display("test freeze and reset done");
        wr(8'h20, 32'hffff_ffff, bx_pkg::RESP_SLVERR);
        rd(8'h20, 32'h0000_0000, bx_pkg::RESP_SLVERR);
        check_all(1'b0);
        $display("test unmapped done");
        complete_run();
    end
endmodule

`default_nettype wire
